// ==== core/swr_regs.sv ====
// Purpose: Selective wake configuration register bank behind the serial port
// Assumes: Serial frame decoder delivers one-cycle read and write strobes on clk
// Notes: arst_n is power-on reset; restart and soft reset are synchronous pulses
`timescale 1ns/1ps
module swr_regs
  import swr_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // Device events, one-cycle pulses
  input wire logic softRst,
  input wire logic restartEvt,
  input wire logic wakeUpEvt,
  // Device mode, one-hot
  input wire swr_pkg::swr_mode_type devMode,
  // Register access from the serial decoder
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [swr_pkg::ADDR_W-1:0] regAddr,
  input wire logic [swr_pkg::DATA_W-1:0] wrData,
  output logic [swr_pkg::DATA_W-1:0] rdData,
  output logic rdValid,
  // Bus time-out raw event and transmit pin
  input wire logic busTimeoutEvt,
  input wire logic busTransmitInputPin,
  // Outputs to the wake logic and pins
  output logic interruptOutPin_n,
  output logic busTimeoutFlag,
  output logic selectiveWakeEn,
  output logic oscTrimActive,
  output logic trimRefSample,
  output logic [7:0] quantaPerBit,
  output logic [5:0] samplePointFraction,
  output logic [28:0] wakeIdent,
  output logic [10:0] wakeIdentStd,
  output logic wakeIdentExt,
  output logic [7:0] lowPowerReceiverOption
);

  import swr_pkg::*;

  // Address decode helper, used for every register select
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Named selects
  wire selScrLo = hit(regAddr, OFS_SCRATCH_LO);
  wire selScrHi = hit(regAddr, OFS_SCRATCH_HI);
  wire selCtrl = hit(regAddr, OFS_WAKE_CTRL);
  wire selQuanta = hit(regAddr, OFS_BIT_QUANTA);
  wire selSample = hit(regAddr, OFS_SAMPLE_PT);
  wire selIdTop = hit(regAddr, OFS_IDENT_TOP);
  wire selIdUmid = hit(regAddr, OFS_IDENT_UMID);
  wire selIdLmid = hit(regAddr, OFS_IDENT_LMID);
  wire selIdBot = hit(regAddr, OFS_IDENT_BOT);
  wire selRxOpt = hit(regAddr, OFS_RX_OPTION);

  wire inNormal = (devMode == MODE_NORMAL);
  wire inStop = (devMode == MODE_STOP);

  logic [7:0] scrLo_q;
  logic [7:0] scrHi_q;
  logic [7:0] ctrlVal;
  logic [7:0] quantaVal;
  logic [7:0] sampleVal;
  logic [7:0] idTopVal;
  logic [7:0] idUmidVal;
  logic [7:0] idLmidVal;
  logic [7:0] idBotVal;
  logic [7:0] rxOptVal;
  logic setupValid_q;
  logic setupValid_d;
  logic timeoutFlag_q;
  logic irqLine_q;
  logic [7:0] rdData_q;
  logic rdValid_q;
  logic trimSync1_q;
  logic trimSync2_q;
  logic trimRef_q;

  wire trimUnlocked = (ctrlVal[POS_UNLOCK_HI:POS_UNLOCK_LO] == UNLOCK_KEY);
  wire scratchWrOk = wrStb && inNormal;
  wire rxOptWrOk = wrStb && selRxOpt && trimUnlocked;

  // Any host write to timing or identifier data counts as a setup change
  wire cfgChange = wrStb && (selQuanta || selSample || selIdTop || selIdUmid
                   || selIdLmid || selIdBot);

  // Scratch bytes: only power-on clears them, no internal source writes them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scrLo_q <= RST_SCRATCH;
      scrHi_q <= RST_SCRATCH;
    end else begin
      if (scratchWrOk && selScrLo) begin
        scrLo_q <= wrData;
      end
      if (scratchWrOk && selScrHi) begin
        scrHi_q <= wrData;
      end
    end
  end

  // Control register; setup-valid bit lives apart because hardware clears it
  swr_cfg_reg #(
    .RESET_VAL(RST_WAKE_CTRL),
    .WR_MASK(MASK_WAKE_CTRL & 8'hFE),
    .RESTART_CLR(~MASK_UPPER_NIB),
    .SOFT_KEEP(1'b0)
  ) uCtrl (
    .clk(clk),
    .arst_n(arst_n),
    .softRst(softRst),
    .restart(restartEvt),
    .wrEn(wrStb && selCtrl),
    .wrData(wrData),
    .value(ctrlVal)
  );

  // Timing and identifier registers share the same reset handling
  swr_cfg_reg #(.RESET_VAL(RST_BIT_QUANTA)) uQuanta (
    .clk(clk), .arst_n(arst_n), .softRst(softRst), .restart(restartEvt),
    .wrEn(wrStb && selQuanta), .wrData(wrData), .value(quantaVal)
  );
  swr_cfg_reg #(.RESET_VAL(RST_SAMPLE_PT), .WR_MASK(MASK_SAMPLE_PT)) uSample (
    .clk(clk), .arst_n(arst_n), .softRst(softRst), .restart(restartEvt),
    .wrEn(wrStb && selSample), .wrData(wrData), .value(sampleVal)
  );
  swr_cfg_reg #(.RESET_VAL(RST_IDENT)) uIdTop (
    .clk(clk), .arst_n(arst_n), .softRst(softRst), .restart(restartEvt),
    .wrEn(wrStb && selIdTop), .wrData(wrData), .value(idTopVal)
  );
  swr_cfg_reg #(.RESET_VAL(RST_IDENT)) uIdUmid (
    .clk(clk), .arst_n(arst_n), .softRst(softRst), .restart(restartEvt),
    .wrEn(wrStb && selIdUmid), .wrData(wrData), .value(idUmidVal)
  );
  swr_cfg_reg #(.RESET_VAL(RST_IDENT)) uIdLmid (
    .clk(clk), .arst_n(arst_n), .softRst(softRst), .restart(restartEvt),
    .wrEn(wrStb && selIdLmid), .wrData(wrData), .value(idLmidVal)
  );
  swr_cfg_reg #(.RESET_VAL(RST_IDENT), .WR_MASK(MASK_IDENT_BOT)) uIdBot (
    .clk(clk), .arst_n(arst_n), .softRst(softRst), .restart(restartEvt),
    .wrEn(wrStb && selIdBot), .wrData(wrData), .value(idBotVal)
  );
  swr_cfg_reg #(.RESET_VAL(RST_RX_OPTION)) uRxOpt (
    .clk(clk), .arst_n(arst_n), .softRst(softRst), .restart(restartEvt),
    .wrEn(rxOptWrOk), .wrData(wrData), .value(rxOptVal)
  );

  // Setup-valid: clears win over a host set, since stale config must not wake
  always_comb begin
    setupValid_d = setupValid_q;
    if (wrStb && selCtrl) begin
      setupValid_d = wrData[POS_SETUP_VALID];
    end
    if (wakeUpEvt || cfgChange || softRst || restartEvt) begin
      setupValid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      setupValid_q <= 1'b0;
    end else begin
      setupValid_q <= setupValid_d;
    end
  end

  // Time-out flag follows the raw event only while selective wake is on in normal or stop mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timeoutFlag_q <= 1'b0;
    end else if (setupValid_q && (inNormal || inStop)) begin
      timeoutFlag_q <= busTimeoutEvt;
    end
  end

  // Interrupt line is low while an unmasked time-out is present
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqLine_q <= 1'b1;
    end else begin
      irqLine_q <= ~(timeoutFlag_q && ctrlVal[POS_TO_IRQ_EN]);
    end
  end

  // Transmit pin is asynchronous; three flops before the trim logic sees it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trimSync1_q <= 1'b1;
      trimSync2_q <= 1'b1;
      trimRef_q <= 1'b1;
    end else begin
      trimSync1_q <= busTransmitInputPin;
      trimSync2_q <= trimSync1_q;
      trimRef_q <= trimSync2_q;
    end
  end

  // Read mux; scratch bytes are readable in any mode, stop mode included
  wire [7:0] rdMux =
      selScrLo ? scrLo_q :
      selScrHi ? scrHi_q :
      selCtrl ? ((ctrlVal & MASK_WAKE_CTRL) | {7'h00, setupValid_q}) :
      selQuanta ? quantaVal :
      selSample ? sampleVal :
      selIdTop ? idTopVal :
      selIdUmid ? idUmidVal :
      selIdLmid ? idLmidVal :
      selIdBot ? idBotVal :
      selRxOpt ? rxOptVal : 8'h00;

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= rdStb;
      if (rdStb) begin
        rdData_q <= rdMux;
      end
    end
  end

  // Registered configuration outputs toward the wake decoder
  logic trimActive_q;
  logic [28:0] ident_q;
  logic [10:0] identStd_q;
  logic identExt_q;
  logic swkEn_q;
  logic [7:0] quanta_q;
  logic [5:0] sample_q;
  logic [7:0] rxOpt_q;

  wire [28:0] identCat = {idTopVal, idUmidVal, idLmidVal, idBotVal[6:2]};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trimActive_q <= 1'b0;
      ident_q <= 29'h0000000;
      identStd_q <= 11'h000;
      identExt_q <= 1'b0;
      swkEn_q <= 1'b0;
      quanta_q <= RST_BIT_QUANTA;
      sample_q <= RST_SAMPLE_PT[5:0];
      rxOpt_q <= RST_RX_OPTION;
    end else begin
      trimActive_q <= ctrlVal[POS_TRIM_MODE] && trimUnlocked;
      ident_q <= identCat;
      identStd_q <= identCat[28:18];
      identExt_q <= idBotVal[POS_IDENT_EXT];
      swkEn_q <= setupValid_q;
      quanta_q <= quantaVal;
      sample_q <= sampleVal[5:0];
      rxOpt_q <= rxOptVal;
    end
  end

  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign interruptOutPin_n = irqLine_q;
  assign busTimeoutFlag = timeoutFlag_q;
  assign selectiveWakeEn = swkEn_q;
  assign oscTrimActive = trimActive_q;
  assign trimRefSample = trimRef_q;
  assign quantaPerBit = quanta_q;
  assign samplePointFraction = sample_q;
  assign wakeIdent = ident_q;
  assign wakeIdentStd = identStd_q;
  assign wakeIdentExt = identExt_q;
  assign lowPowerReceiverOption = rxOpt_q;

endmodule : swr_regs

// ==== core/swr_pkg.sv ====
// Purpose: Shared constants for the selective wake configuration register bank
// Assumes: 7-bit register addresses, 8-bit data
// Notes: Offsets are the printed register addresses
package swr_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [6:0] OFS_SCRATCH_LO = 7'h1E;
  localparam logic [6:0] OFS_SCRATCH_HI = 7'h1F;
  localparam logic [6:0] OFS_WAKE_CTRL = 7'h20;
  localparam logic [6:0] OFS_BIT_QUANTA = 7'h21;
  localparam logic [6:0] OFS_SAMPLE_PT = 7'h22;
  localparam logic [6:0] OFS_IDENT_TOP = 7'h23;
  localparam logic [6:0] OFS_IDENT_UMID = 7'h24;
  localparam logic [6:0] OFS_IDENT_LMID = 7'h25;
  localparam logic [6:0] OFS_IDENT_BOT = 7'h26;
  localparam logic [6:0] OFS_RX_OPTION = 7'h35;

  // Reset values
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_WAKE_CTRL = 8'h00;
  localparam logic [7:0] RST_BIT_QUANTA = 8'hA0;
  localparam logic [7:0] RST_SAMPLE_PT = 8'h33;
  localparam logic [7:0] RST_IDENT = 8'h00;
  localparam logic [7:0] RST_RX_OPTION = 8'h00;

  // Control register field positions
  localparam int unsigned POS_TRIM_MODE = 7;
  localparam int unsigned POS_UNLOCK_HI = 6;
  localparam int unsigned POS_UNLOCK_LO = 5;
  localparam int unsigned POS_TO_IRQ_EN = 4;
  localparam int unsigned POS_SETUP_VALID = 0;
  localparam logic [1:0] UNLOCK_KEY = 2'h3;

  // Writable masks; cleared bits are reserved and read as zero. MASK_UPPER_NIB instead marks the control bits that restart keeps
  localparam logic [7:0] MASK_WAKE_CTRL = 8'hF1;
  localparam logic [7:0] MASK_SAMPLE_PT = 8'h3F;
  localparam logic [7:0] MASK_IDENT_BOT = 8'h7F;
  localparam logic [7:0] MASK_UPPER_NIB = 8'hF0;

  // Identifier flag positions in the bottom register
  localparam int unsigned POS_IDENT_EXT = 0;
  localparam int unsigned POS_REMOTE_REQ = 1;

  // Device operating modes
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_STOP = 4'b0010,
    MODE_RESTART = 4'b0100,
    MODE_FAILSAFE = 4'b1000
  } swr_mode_type;

endpackage : swr_pkg

// ==== core/swr_cfg_reg.sv ====
// Purpose: One 8-bit configuration register with masked write and event resets
// Assumes: Restart and soft reset are one-cycle pulses on clk
// Notes: Reserved bits are held at zero by the write mask
`timescale 1ns/1ps
module swr_cfg_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF,
  parameter logic [7:0] RESTART_CLR = 8'h00,
  parameter bit SOFT_KEEP = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Events
  input wire logic softRst,
  input wire logic restart,
  // Write port
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  // Stored value
  output logic [7:0] value
);

  logic [7:0] regQ;
  logic [7:0] regD;

  // Soft reset wins over restart and write; restart clears only chosen bits
  always_comb begin
    regD = regQ;
    if (softRst && !SOFT_KEEP) begin
      regD = RESET_VAL & WR_MASK;
    end else if (restart) begin
      regD = regQ & ~RESTART_CLR;
    end else if (wrEn) begin
      regD = wrData & WR_MASK;
    end
  end

  // Storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regQ <= RESET_VAL & WR_MASK;
    end else begin
      regQ <= regD;
    end
  end

  assign value = regQ;

endmodule : swr_cfg_reg

// ==== verification/swr_regs_monitor.sv ====
// Purpose: Port-level checks on the wake register bank
// Assumes: One clock domain, arst_n asynchronous and active low
// Notes: Bound onto every swr_regs instance
`timescale 1ns/1ps
module swr_regs_monitor
  import swr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Inputs watched
  input wire logic softRst,
  input wire logic restartEvt,
  input wire logic wakeUpEvt,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [swr_pkg::ADDR_W-1:0] regAddr,
  input wire logic [swr_pkg::DATA_W-1:0] wrData,
  input wire logic busTransmitInputPin,
  // Outputs watched
  input wire logic [swr_pkg::DATA_W-1:0] rdData,
  input wire logic rdValid,
  input wire logic selectiveWakeEn,
  input wire logic oscTrimActive,
  input wire logic trimRefSample,
  input wire logic [7:0] quantaPerBit,
  input wire logic [5:0] samplePointFraction,
  input wire logic [28:0] wakeIdent,
  input wire logic [10:0] wakeIdentStd
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Control write, then a cycle with no event that could overwrite it
  sequence ctrl_wr;
    wrStb && regAddr == OFS_WAKE_CTRL ##1 !softRst && !restartEvt;
  endsequence
  // Any write of timing or identifier data
  sequence cfg_wr;
    wrStb && regAddr >= OFS_BIT_QUANTA && regAddr <= OFS_IDENT_BOT;
  endsequence
  read_answer_a: assert property (rdStb |=> rdValid)
    else $error("read strobe not answered");
  trim_mode_a: assert property (ctrl_wr |=> oscTrimActive == &$past(wrData[7:5], 2))
    else $error("trim state does not follow control write");
  reserved_zero_a: assert property (rdStb && regAddr == OFS_WAKE_CTRL |=>
    (rdData & ~MASK_WAKE_CTRL) == 8'h00) else $error("reserved control bits not zero");
  cfg_change_a: assert property (cfg_wr |-> ##2 !selectiveWakeEn)
    else $error("wake enable kept after config change");
  wake_clear_a: assert property (wakeUpEvt |-> ##2 !selectiveWakeEn)
    else $error("wake enable kept after wake-up");
  restart_clear_a: assert property (restartEvt |-> ##2 !selectiveWakeEn)
    else $error("wake enable kept after restart");
  soft_defaults_a: assert property (softRst |-> ##2 quantaPerBit == RST_BIT_QUANTA &&
    samplePointFraction == RST_SAMPLE_PT[5:0] && wakeIdent == 29'h0)
    else $error("timing or identifier not reset by soft reset");
  std_ident_a: assert property (wakeIdentStd == wakeIdent[28:18])
    else $error("standard identifier misplaced");
  trim_sample_a: assert property (trimRefSample == $past(busTransmitInputPin, 3))
    else $error("trim reference not taken from transmit pin");
endmodule : swr_regs_monitor

bind swr_regs swr_regs_monitor u_mon (.clk, .arst_n, .softRst, .restartEvt, .wakeUpEvt,
  .wrStb, .rdStb, .regAddr, .wrData, .busTransmitInputPin, .rdData, .rdValid,
  .selectiveWakeEn, .oscTrimActive, .trimRefSample, .quantaPerBit, .samplePointFraction,
  .wakeIdent, .wakeIdentStd);

// ==== verification/swr_host_model.sv ====
// Purpose: Host side drive of the transmit pin
// Assumes: Host changes the pin on the falling edge
// Notes: Pin idles recessive high outside calibration
`timescale 1ns/1ps
module swr_host_model (
  // Clock
  input wire logic clk,
  // Calibration state seen by the host
  input wire logic trimOn,
  // Reference pin
  output logic txPin
);
  logic [1:0] divQ;
  // Reference toggles every 4 cycles while trimming, so edges stay countable
  always @(negedge clk) begin
    divQ <= trimOn ? divQ + 2'h1 : 2'h0;
    txPin <= trimOn ? (divQ == 2'h3 ? ~txPin : txPin) : 1'b1;
  end
  initial begin
    txPin = 1'b1;
    divQ = 2'h0;
  end
endmodule : swr_host_model

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the wake register bank
// Assumes: Inputs change on the falling edge
// Notes: Read results are queued by the driver and checked on rdValid
`timescale 1ns/1ps
module testbench;
  import swr_pkg::*;
  logic clk, arst_n, softRst, restartEvt, wakeUpEvt, wrStb, rdStb, rdValid;
  logic busTimeoutEvt, busTransmitInputPin, interruptOutPin_n, busTimeoutFlag;
  logic selectiveWakeEn, oscTrimActive, trimRefSample, wakeIdentExt;
  swr_mode_type devMode;
  logic [6:0] regAddr;
  logic [7:0] wrData, rdData, quantaPerBit, lowPowerReceiverOption, d;
  logic [5:0] samplePointFraction;
  logic [28:0] wakeIdent;
  logic [10:0] wakeIdentStd;
  logic [7:0] expQ[$];
  logic [7:0] v[6];
  logic [7:0] rstVals[9] = '{8'h00, 8'h00, 8'h00, 8'hA0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00};
  int miscompares, testsRun, cycles, seed, i;

  swr_regs dut (.clk, .arst_n, .softRst, .restartEvt, .wakeUpEvt, .devMode, .wrStb, .rdStb,
    .regAddr, .wrData, .rdData, .rdValid, .busTimeoutEvt, .busTransmitInputPin,
    .interruptOutPin_n, .busTimeoutFlag, .selectiveWakeEn, .oscTrimActive, .trimRefSample,
    .quantaPerBit, .samplePointFraction, .wakeIdent, .wakeIdentStd, .wakeIdentExt,
    .lowPowerReceiverOption);
  swr_host_model host (.clk, .trimOn(oscTrimActive), .txPin(busTransmitInputPin));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] val);
    @(negedge clk);
    wrStb = 1'b1;
    regAddr = a;
    wrData = val;
    @(negedge clk);
    wrStb = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk);
    rdStb = 1'b1;
    regAddr = a;
    expQ.push_back(e);
    @(negedge clk);
    rdStb = 1'b0;
  endtask : rd
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse
  task automatic wrap_up();
    if (miscompares == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Read results checked against the oldest queued note
  always @(negedge clk) begin
    if (rdValid === 1'b1) begin
      chk(rdData, expQ.pop_front());
    end
  end
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    seed = 52695;
    {softRst, restartEvt, wakeUpEvt, wrStb, rdStb, busTimeoutEvt} = 6'h00;
    regAddr = 7'h00;
    wrData = 8'h00;
    devMode = MODE_NORMAL;
    arst_n = 1'b0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    for (i = 0; i < 9; i++) rd(OFS_SCRATCH_LO + 7'(i), rstVals[i]);
    // Scratch word: refused outside normal mode, kept through resets
    d = 8'($random(seed));
    wr(OFS_SCRATCH_LO, d);
    wr(OFS_SCRATCH_HI, ~d);
    devMode = MODE_STOP;
    wr(OFS_SCRATCH_LO, d ^ 8'h5A);
    rd(OFS_SCRATCH_LO, d);
    devMode = MODE_NORMAL;
    pulse(softRst);
    pulse(restartEvt);
    rd(OFS_SCRATCH_LO, d);
    rd(OFS_SCRATCH_HI, ~d);
    // Control fields, reserved bits and restart
    wr(OFS_WAKE_CTRL, 8'hFF);
    rd(OFS_WAKE_CTRL, 8'hF1);
    chk({7'h0, oscTrimActive}, 8'h01);
    chk({7'h0, selectiveWakeEn}, 8'h01);
    pulse(restartEvt);
    rd(OFS_WAKE_CTRL, 8'hF0);
    wr(OFS_WAKE_CTRL, 8'h61);
    wr(OFS_RX_OPTION, 8'hC3);
    chk({7'h0, oscTrimActive}, 8'h00);
    wr(OFS_WAKE_CTRL, 8'h41);
    wr(OFS_RX_OPTION, 8'h3C);
    rd(OFS_RX_OPTION, 8'hC3);
    chk(lowPowerReceiverOption, 8'hC3);
    // Random timing and identifier data; host keeps remote request clear
    for (i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      d[1] = (i == 5) ? 1'b0 : d[1];
      v[i] = d & ((i == 1) ? MASK_SAMPLE_PT : (i == 5) ? MASK_IDENT_BOT : 8'hFF);
      wr(OFS_BIT_QUANTA + 7'(i), d);
      rd(OFS_BIT_QUANTA + 7'(i), v[i]);
    end
    rd(OFS_WAKE_CTRL, 8'h40);
    chk(quantaPerBit, v[0]);
    chk({2'h0, samplePointFraction}, v[1]);
    chk(wakeIdent[28:21], v[2]);
    chk(wakeIdent[20:13], v[3]);
    chk(wakeIdent[12:5], v[4]);
    chk({3'h0, wakeIdent[4:0]}, {3'h0, v[5][6:2]});
    chk({5'h0, wakeIdentStd[2:0]}, {5'h0, v[3][7:5]});
    chk({7'h0, wakeIdentExt}, {7'h0, v[5][0]});
    wr(OFS_WAKE_CTRL, 8'h01);
    pulse(wakeUpEvt);
    rd(OFS_WAKE_CTRL, 8'h00);
    pulse(restartEvt);
    rd(OFS_IDENT_TOP, v[2]);
    pulse(softRst);
    rd(OFS_IDENT_TOP, 8'h00);
    rd(7'h7F, 8'h00);
    // Time-out flag and interrupt masking; the raw time-out is a level, held high
    // so that a flag which wrongly updates while wake is off would be seen
    busTimeoutEvt = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h0, busTimeoutFlag}, 8'h00);
    wr(OFS_WAKE_CTRL, 8'h01);
    repeat (3) @(negedge clk);
    chk({7'h0, busTimeoutFlag}, 8'h01);
    chk({7'h0, interruptOutPin_n}, 8'h01);
    wr(OFS_WAKE_CTRL, 8'h11);
    repeat (3) @(negedge clk);
    chk({7'h0, interruptOutPin_n}, 8'h00);
    // Outside normal and stop the flag must hold, even when the raw level drops
    devMode = MODE_FAILSAFE;
    busTimeoutEvt = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h0, busTimeoutFlag}, 8'h01);
    repeat (3) @(negedge clk);
    wrap_up();
  end
endmodule : testbench
